// ---- include/trm_defs.svh ----
// constants of the transceiver reconfiguration manager
`ifndef TRM_DEFS_SVH
`define TRM_DEFS_SVH
// channel and pll counts
`define TRM_NUM_CH 4
`define TRM_NUM_PLL 2
// request port word addresses
`define TRM_A_STATUS 3'h0
`define TRM_A_REFCLK 3'h1
`define TRM_A_DIV 3'h2
`define TRM_A_CHAN 3'h3
`define TRM_A_PLL 3'h4
`define TRM_A_EYE 3'h5
`define TRM_A_AEQ 3'h6
// write data field positions
`define TRM_F_IDX 0
`define TRM_F_TGT 2
`define TRM_F_VAL 4
`define TRM_F_PSEL 6
`define TRM_F_PART 7
`define TRM_F_PCS 8
`define TRM_F_WID 12
`define TRM_F_SRC 12
`define TRM_F_DIR 14
`define TRM_F_BOND 16
`define TRM_F_DIRECT 18
`define TRM_F_CORE 19
`define TRM_F_AEQ 20
// status word field positions
`define TRM_S_ERR 0
`define TRM_S_BUSY 1
`define TRM_S_EYE 2
`define TRM_S_FLD 8
// codes
`define TRM_SRC_DEDICATED 2'h0
`define TRM_DIR_TX 2'h1
`define TRM_DIR_RX 2'h2
// reset values
`define TRM_RST_DIV 2'h0
`define TRM_RST_PCS 4'hf
`define TRM_RST_WID 2'h0
`define TRM_RST_SET 2'h0
// timing: one field write takes 32 ns at 125 MHz
`define TRM_CLK_MHZ 125
`define TRM_FIELD_WR_NS 32
`define TRM_FIELD_WR_CYC ((`TRM_FIELD_WR_NS * `TRM_CLK_MHZ + 999) / 1000)
`define TRM_PI_STEPS 32
`define TRM_EYE_DWELL 16
`define TRM_EQ_MAX 4'hf
`endif

// ---- include/trm_pkg.sv ----
// types of the transceiver reconfiguration manager
`include "trm_defs.svh"
package trm_pkg;
    typedef enum logic [1:0] {TRM_IDLE, TRM_WRITE, TRM_EYE} trm_state_t;

    typedef struct packed {
        trm_state_t state;
        logic busy;
        logic err;
        logic [7:0] cnt;
        logic [2*`TRM_NUM_CH-1:0] ch_div;
        logic [`TRM_NUM_CH-1:0] ch_pll;
        logic [2*`TRM_NUM_CH-1:0] ch_cdr;
        logic [4*`TRM_NUM_CH-1:0] ch_pcs;
        logic [2*`TRM_NUM_CH-1:0] ch_wid;
        logic [2*`TRM_NUM_CH-1:0] ch_rate;
        logic [2*`TRM_NUM_CH-1:0] ch_ref;
        logic [2*`TRM_NUM_PLL-1:0] pll_ref;
        logic [2*`TRM_NUM_PLL-1:0] pll_set;
        logic [3:0] fields;
        logic eye_start;
        logic [1:0] eye_ch;
        logic [5:0] eye_w;
        logic aeq_en;
        logic [1:0] aeq_ch;
        logic [31:0] rdata;
        logic rvalid;
    } trm_top_s_t;

    typedef struct packed {
        logic run;
        logic [4:0] phase;
        logic [7:0] dwell;
        logic bad;
        logic [5:0] width;
        logic done;
    } trm_eye_s_t;

    typedef struct packed {
        logic [5:0] tick;
        logic [3:0] eq;
    } trm_aeq_s_t;
endpackage : trm_pkg

// ---- rtl/trm_adapt_eq.sv ----
// adaptive equalizer: nudges the receive equalizer toward the reference
`timescale 1ns/1ns
`default_nettype none
module trm_adapt_eq
    import trm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic [7:0] sig_level_in,
    input wire logic [7:0] ref_level_in,
    output logic [3:0] eq_out
);
    trm_aeq_s_t s_reg;
    trm_aeq_s_t s_next;

    ////////////////////////////////////////////////////////////////////////
    // compare once per tick wrap so the loop settles, not chatters
    always_comb
    begin
        s_next = s_reg;
        if (!enable_in)
            s_next.tick = 6'h00;
        else
        begin
            s_next.tick = s_reg.tick + 6'h01;
            if (s_reg.tick == 6'h3f)
            begin
                if (sig_level_in < ref_level_in && s_reg.eq != `TRM_EQ_MAX)
                    s_next.eq = s_reg.eq + 4'h1;
                else if (sig_level_in > ref_level_in && s_reg.eq != 4'h0)
                    s_next.eq = s_reg.eq - 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign eq_out = s_reg.eq;
endmodule : trm_adapt_eq
`default_nettype wire

// ---- rtl/trm_eye_scan.sv ----
// eye width scan: steps the phase interpolator and counts clean steps
`timescale 1ns/1ns
`default_nettype none
module trm_eye_scan
    import trm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic err_in,
    output logic [4:0] phase_out,
    output logic done_out,
    output logic [5:0] width_out
);
    trm_eye_s_t s_reg;
    trm_eye_s_t s_next;

    ////////////////////////////////////////////////////////////////////////
    // one dwell per phase step; any sampler error spoils the step
    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (start_in)
        begin
            s_next.run = 1'b1;
            s_next.phase = 5'h00;
            s_next.dwell = 8'h00;
            s_next.bad = 1'b0;
            s_next.width = 6'h00;
        end
        else if (s_reg.run)
        begin
            s_next.bad = s_reg.bad | err_in;
            if (s_reg.dwell == 8'(`TRM_EYE_DWELL - 1))
            begin
                s_next.dwell = 8'h00;
                s_next.bad = 1'b0;
                if (!(s_reg.bad | err_in))
                    s_next.width = s_reg.width + 6'h01;
                if (s_reg.phase == 5'(`TRM_PI_STEPS - 1))
                begin
                    s_next.run = 1'b0;
                    s_next.done = 1'b1;
                end
                else
                    s_next.phase = s_reg.phase + 5'h01;
            end
            else
                s_next.dwell = s_reg.dwell + 8'h01;
        end
    end

    // state register
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign phase_out = s_reg.phase;
    assign done_out = s_reg.done;
    assign width_out = s_reg.width;
endmodule : trm_eye_scan
`default_nettype wire

// ---- rtl/trm_top.sv ----
// transceiver reconfiguration manager: request port, checks and state
//
// Function
// - reference clock of pll or cdr switchable
// - only dedicated reference pin may be selected
// - requests arrive on a memory-mapped port
// - per-channel transmit divider of 1,2,4,8
// - cdr rate and pcs sub-block enables reprogrammable
// - channel may pick alternate pll in block
// - fabric-to-channel width reprogrammable
// - channel change touches only addressed channel
// - pll change reaches every channel using it
// - no tx-only to rx-only swap, or reverse
// - no bonding or lane-count changes
// - no direct analog mode switching
// - refuse pll change when driving bonded channels
// - no core switching, only sub-block enables
// - partial update writes only differing settings
// - eye scan steps phase, checks sampler errors
// - eye width counts clean steps, zero closed
// - adaptive equalizer enabled through request port
// - busy high during operation, requester waits
`timescale 1ns/1ns
`default_nettype none
`include "trm_defs.svh"
module trm_top
    import trm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [2:0] avmm_address_in,
    input wire logic avmm_write_in,
    input wire logic avmm_read_in,
    input wire logic [31:0] avmm_writedata_in,
    output logic [31:0] avmm_readdata_out,
    output logic avmm_readdatavalid_out,
    output logic avmm_waitrequest_out,
    output logic busy_out,
    output logic error_out,
    input wire logic [2*`TRM_NUM_CH-1:0] ch_dir_in,
    input wire logic [2*`TRM_NUM_CH-1:0] ch_bond_in,
    input wire logic [`TRM_NUM_CH-1:0] ch_direct_in,
    input wire logic [`TRM_NUM_CH-1:0] ch_core_in,
    input wire logic [`TRM_NUM_CH-1:0] eye_sampler_err_in,
    input wire logic [7:0] aeq_sig_level_in,
    input wire logic [7:0] aeq_ref_level_in,
    output logic [2*`TRM_NUM_CH-1:0] tx_div_out,
    output logic [`TRM_NUM_CH-1:0] pll_sel_out,
    output logic [2*`TRM_NUM_CH-1:0] cdr_rate_out,
    output logic [4*`TRM_NUM_CH-1:0] pcs_en_out,
    output logic [2*`TRM_NUM_CH-1:0] width_out,
    output logic [2*`TRM_NUM_CH-1:0] tx_rate_out,
    output logic [2*`TRM_NUM_CH-1:0] cdr_refclk_out,
    output logic [2*`TRM_NUM_PLL-1:0] pll_refclk_out,
    output logic [2*`TRM_NUM_PLL-1:0] pll_setting_out,
    output logic [3:0] fields_written_out,
    output logic [4:0] phase_interpolator_phase_out,
    output logic [1:0] eye_sampler_ch_out,
    output logic [5:0] eye_width_out,
    output logic [1:0] adaptive_equalizer_ch_out,
    output logic [3:0] adaptive_equalizer_eq_out
);
    trm_top_s_t s_reg;
    trm_top_s_t s_next;

    logic acc;
    logic [1:0] idx;
    logic [1:0] val;
    logic psel;
    logic part;
    logic [3:0] pcs;
    logic [1:0] wid;
    logic [1:0] src;
    logic [3:0] diff;
    logic [3:0] wmask;
    logic [2:0] nfld;
    logic bad_chan;
    logic pll_bonded;
    logic eye_err;
    logic eye_done;
    logic [5:0] eye_width;

    ////////////////////////////////////////////////////////////////////////
    // request decode; writes stall while busy so none is lost
    assign acc = avmm_write_in && !s_reg.busy;
    assign idx = avmm_writedata_in[`TRM_F_IDX +: 2];
    assign val = avmm_writedata_in[`TRM_F_VAL +: 2];
    assign psel = avmm_writedata_in[`TRM_F_PSEL];
    assign part = avmm_writedata_in[`TRM_F_PART];
    assign pcs = avmm_writedata_in[`TRM_F_PCS +: 4];
    assign wid = avmm_writedata_in[`TRM_F_WID +: 2];
    assign src = avmm_writedata_in[`TRM_F_SRC +: 2];

    // settings that differ from the channel as it stands now
    assign diff[0] = s_reg.ch_pll[idx] != psel;
    assign diff[1] = s_reg.ch_cdr[idx*2 +: 2] != val;
    assign diff[2] = s_reg.ch_pcs[idx*4 +: 4] != pcs;
    assign diff[3] = s_reg.ch_wid[idx*2 +: 2] != wid;
    assign wmask = part ? diff : 4'hf;
    assign nfld = {2'b00, wmask[0]} + {2'b00, wmask[1]} + {2'b00, wmask[2]}
                + {2'b00, wmask[3]};

    ////////////////////////////////////////////////////////////////////////
    // unsupported channel transitions, judged against live configuration
    always_comb
    begin
        bad_chan = 1'b0;
        if (ch_dir_in[idx*2 +: 2] == `TRM_DIR_TX
            && avmm_writedata_in[`TRM_F_DIR +: 2] == `TRM_DIR_RX)
            bad_chan = 1'b1;
        if (ch_dir_in[idx*2 +: 2] == `TRM_DIR_RX
            && avmm_writedata_in[`TRM_F_DIR +: 2] == `TRM_DIR_TX)
            bad_chan = 1'b1;
        if (ch_bond_in[idx*2 +: 2] != avmm_writedata_in[`TRM_F_BOND +: 2])
            bad_chan = 1'b1;
        if (ch_direct_in[idx] != avmm_writedata_in[`TRM_F_DIRECT])
            bad_chan = 1'b1;
        if (ch_core_in[idx] != avmm_writedata_in[`TRM_F_CORE])
            bad_chan = 1'b1;
    end

    // a pll that clocks any bonded channel is locked against setting change, not against refclk change
    always_comb
    begin
        pll_bonded = 1'b0;
        for (int i = 0; i < `TRM_NUM_CH; i++)
        begin
            if (s_reg.ch_pll[i] == idx[0] && ch_bond_in[i*2 +: 2] != 2'h0)
                pll_bonded = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequencer and register updates
    always_comb
    begin
        s_next = s_reg;
        s_next.rvalid = 1'b0;
        s_next.eye_start = 1'b0;
        if (avmm_read_in)
        begin
            s_next.rvalid = 1'b1;
            s_next.rdata = 32'h0;
            if (avmm_address_in == `TRM_A_STATUS)
            begin
                s_next.rdata[`TRM_S_ERR] = s_reg.err;
                s_next.rdata[`TRM_S_BUSY] = s_reg.busy;
                s_next.rdata[`TRM_S_EYE +: 6] = s_reg.eye_w;
                s_next.rdata[`TRM_S_FLD +: 4] = s_reg.fields;
            end
        end
        case (s_reg.state)
            TRM_IDLE:
            begin
                if (acc)
                begin
                    case (avmm_address_in)
                        `TRM_A_STATUS:
                        begin
                            // write one to clear the error flag
                            if (avmm_writedata_in[`TRM_S_ERR])
                                s_next.err = 1'b0;
                        end
                        `TRM_A_REFCLK:
                        begin
                            if (src != `TRM_SRC_DEDICATED)
                                s_next.err = 1'b1;
                            else
                            begin
                                if (avmm_writedata_in[`TRM_F_TGT])
                                    s_next.ch_ref[idx*2 +: 2] = val;
                                else
                                    s_next.pll_ref[idx[0]*2 +: 2] = val;
                                s_next.state = TRM_WRITE;
                                s_next.busy = 1'b1;
                                s_next.cnt = 8'(`TRM_FIELD_WR_CYC);
                            end
                        end
                        `TRM_A_DIV:
                        begin
                            // the requester vouches the mode fits the new rate
                            s_next.ch_div[idx*2 +: 2] = val;
                            s_next.state = TRM_WRITE;
                            s_next.busy = 1'b1;
                            s_next.cnt = 8'(`TRM_FIELD_WR_CYC);
                        end
                        `TRM_A_CHAN:
                        begin
                            if (bad_chan)
                                s_next.err = 1'b1;
                            else
                            begin
                                if (wmask[0])
                                    s_next.ch_pll[idx] = psel;
                                if (wmask[1])
                                    s_next.ch_cdr[idx*2 +: 2] = val;
                                if (wmask[2])
                                    s_next.ch_pcs[idx*4 +: 4] = pcs;
                                if (wmask[3])
                                    s_next.ch_wid[idx*2 +: 2] = wid;
                                s_next.fields = wmask;
                                s_next.state = TRM_WRITE;
                                s_next.busy = 1'b1;
                                // nothing to write still costs one cycle
                                if (nfld == 3'h0)
                                    s_next.cnt = 8'h01;
                                else
                                    s_next.cnt = 8'(nfld) * 8'(`TRM_FIELD_WR_CYC);
                            end
                        end
                        `TRM_A_PLL:
                        begin
                            if (pll_bonded)
                                s_next.err = 1'b1;
                            else
                            begin
                                s_next.pll_set[idx[0]*2 +: 2] = val;
                                s_next.state = TRM_WRITE;
                                s_next.busy = 1'b1;
                                s_next.cnt = 8'(`TRM_FIELD_WR_CYC);
                            end
                        end
                        `TRM_A_EYE:
                        begin
                            s_next.eye_start = 1'b1;
                            s_next.eye_ch = idx;
                            s_next.state = TRM_EYE;
                            s_next.busy = 1'b1;
                        end
                        `TRM_A_AEQ:
                        begin
                            s_next.aeq_en = avmm_writedata_in[`TRM_F_AEQ];
                            s_next.aeq_ch = idx;
                        end
                        default:
                        begin
                            // unmapped addresses are ignored
                        end
                    endcase
                end
            end
            TRM_WRITE:
            begin
                s_next.cnt = s_reg.cnt - 8'h01;
                if (s_reg.cnt == 8'h01)
                begin
                    s_next.state = TRM_IDLE;
                    s_next.busy = 1'b0;
                end
            end
            TRM_EYE:
            begin
                if (eye_done)
                begin
                    s_next.eye_w = eye_width;
                    s_next.state = TRM_IDLE;
                    s_next.busy = 1'b0;
                end
            end
            default:
            begin
                s_next.state = TRM_IDLE;
                s_next.busy = 1'b0;
            end
        endcase
        // every channel follows the setting of the pll it sits on
        for (int i = 0; i < `TRM_NUM_CH; i++)
            s_next.ch_rate[i*2 +: 2] = s_next.pll_set[s_next.ch_pll[i]*2 +: 2];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register with documented power-on settings
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_reg <= '0;
            s_reg.state <= TRM_IDLE;
            s_reg.ch_div <= {`TRM_NUM_CH{`TRM_RST_DIV}};
            s_reg.ch_pcs <= {`TRM_NUM_CH{`TRM_RST_PCS}};
            s_reg.ch_wid <= {`TRM_NUM_CH{`TRM_RST_WID}};
            s_reg.pll_set <= {`TRM_NUM_PLL{`TRM_RST_SET}};
            s_reg.ch_rate <= {`TRM_NUM_CH{`TRM_RST_SET}};
        end
        else
            s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // eye scan and adaptive equalizer engines
    assign eye_err = eye_sampler_err_in[s_reg.eye_ch];

    trm_eye_scan u_eye
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(s_reg.eye_start),
        .err_in(eye_err),
        .phase_out(phase_interpolator_phase_out),
        .done_out(eye_done),
        .width_out(eye_width)
    );

    trm_adapt_eq u_aeq
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .enable_in(s_reg.aeq_en),
        .sig_level_in(aeq_sig_level_in),
        .ref_level_in(aeq_ref_level_in),
        .eq_out(adaptive_equalizer_eq_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign avmm_readdata_out = s_reg.rdata;
    assign avmm_readdatavalid_out = s_reg.rvalid;
    assign avmm_waitrequest_out = s_reg.busy;
    assign busy_out = s_reg.busy;
    assign error_out = s_reg.err;
    assign tx_div_out = s_reg.ch_div;
    assign pll_sel_out = s_reg.ch_pll;
    assign cdr_rate_out = s_reg.ch_cdr;
    assign pcs_en_out = s_reg.ch_pcs;
    assign width_out = s_reg.ch_wid;
    assign tx_rate_out = s_reg.ch_rate;
    assign cdr_refclk_out = s_reg.ch_ref;
    assign pll_refclk_out = s_reg.pll_ref;
    assign pll_setting_out = s_reg.pll_set;
    assign fields_written_out = s_reg.fields;
    assign eye_sampler_ch_out = s_reg.eye_ch;
    assign eye_width_out = s_reg.eye_w;
    assign adaptive_equalizer_ch_out = s_reg.aeq_ch;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_busy_stall: assert property ((avmm_write_in && s_reg.busy) |=>
        ($stable(s_reg.ch_div) && $stable(s_reg.ch_pcs) && $stable(s_reg.pll_set)))
        else $error("write taken while busy");
    a_div_apply: assert property ((acc && avmm_address_in == `TRM_A_DIV) |=>
        (s_reg.ch_div[$past(idx)*2 +: 2] == $past(val)) && s_reg.busy)
        else $error("divider not applied");
    a_refclk_src: assert property ((acc && avmm_address_in == `TRM_A_REFCLK
        && src != `TRM_SRC_DEDICATED) |=> s_reg.err && !s_reg.busy
        && $stable(s_reg.pll_ref) && $stable(s_reg.ch_ref))
        else $error("non-dedicated refclk accepted");
    a_chan_reject: assert property ((acc && avmm_address_in == `TRM_A_CHAN
        && bad_chan) |=> s_reg.err && !s_reg.busy && $stable(s_reg.ch_pcs))
        else $error("unsupported channel change accepted");
    a_pll_bond: assert property ((acc && avmm_address_in == `TRM_A_PLL
        && pll_bonded) |=> s_reg.err && $stable(s_reg.pll_set))
        else $error("bonded pll reconfigured");
    a_rate_follow: assert property (s_reg.ch_rate[1:0] ==
        s_reg.pll_set[s_reg.ch_pll[0]*2 +: 2])
        else $error("channel rate does not follow its pll");
    a_partial_len: assert property ((acc && avmm_address_in == `TRM_A_CHAN
        && !bad_chan && part && $onehot(wmask)) |=> s_reg.busy [*4] ##1 !s_reg.busy)
        else $error("partial write length wrong");
    a_other_ch: assert property ((acc && avmm_address_in == `TRM_A_CHAN
        && idx == 2'h0) |=> $stable(s_reg.ch_pcs[15:4]) && $stable(s_reg.ch_wid[7:2]))
        else $error("other channel disturbed");
    a_eye_busy: assert property ((acc && avmm_address_in == `TRM_A_EYE) |=>
        s_reg.busy [*8])
        else $error("eye scan not busy");

    c_partial: cover property (acc && avmm_address_in == `TRM_A_CHAN && part && !bad_chan);
    c_eye_done: cover property (s_reg.state == TRM_EYE && eye_done);
    c_pll_refused: cover property (acc && avmm_address_in == `TRM_A_PLL && pll_bonded);
endmodule : trm_top
`default_nettype wire

// ---- test/trm_req_model.sv ----
// requester model: memory-mapped writes and reads toward the manager
`timescale 1ns/1ns
`default_nettype none
module trm_req_model (
    input wire logic clk_in,
    input wire logic wait_in,
    input wire logic rvalid_in,
    input wire logic [31:0] rdata_in,
    output logic [2:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [31:0] data_out
);
    // idle lines show inverted junk, never the last request
    initial
    begin
        addr_out = 3'h7;
        wr_out = 1'b0;
        rd_out = 1'b0;
        data_out = 32'h0;
    end
    // write held until waitrequest is low at the taking edge
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        data_out = d;
        wr_out = 1'b1;
        do @(negedge clk_in); while (wait_in !== 1'b0);
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~a;
        data_out = ~d;
    endtask : wr
    // read answered one edge later, taken at that edge
    task automatic rd(input logic [2:0] a, output logic [31:0] q);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        addr_out = ~a;
        q = rvalid_in ? rdata_in : 32'hx;
    endtask : rd
endmodule : trm_req_model
`default_nettype wire

// ---- test/trm_top_tb.sv ----
// self-checking testbench of the reconfiguration manager
`timescale 1ns/1ns
`default_nettype none
`include "trm_defs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module trm_top_tb;
    import trm_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [2:0] avmm_address_in;
    logic avmm_write_in, avmm_read_in, avmm_readdatavalid_out, avmm_waitrequest_out;
    logic [31:0] avmm_writedata_in, avmm_readdata_out, q;
    logic busy_out, error_out, closed = 1'b0;
    logic [7:0] ch_dir_in = 8'h01, ch_bond_in = 8'h00;
    logic [3:0] eye_sampler_err_in, pll_sel_out, fields_written_out, aeq_eq;
    logic [3:0] ch_direct_in = 4'h0, ch_core_in = 4'h0;
    logic [1:0] eye_ch, aeq_ch;
    logic [7:0] tx_div_out, cdr_rate_out, width_out, tx_rate_out, cdr_refclk_out;
    logic [15:0] pcs_en_out;
    logic [3:0] pll_refclk_out, pll_setting_out;
    logic [4:0] phase_interpolator_phase_out;
    logic [5:0] eye_width_out;
    int error_cnt = 0, check_count = 0, seed = 7, n, ix, v;
    int div[4] = '{0, 0, 0, 0};
    initial forever #4 clk_in = ~clk_in;
    // sampler fails on the first ten phases, or always when closed
    assign eye_sampler_err_in = closed ? 4'hf : {4{phase_interpolator_phase_out < 5'h0a}};
    trm_top dut (.clk_in, .rst_in, .avmm_address_in, .avmm_write_in, .avmm_read_in,
        .avmm_writedata_in, .avmm_readdata_out, .avmm_readdatavalid_out,
        .avmm_waitrequest_out, .busy_out, .error_out, .ch_dir_in, .ch_bond_in,
        .ch_direct_in, .ch_core_in, .eye_sampler_err_in,
        .aeq_sig_level_in(8'h10), .aeq_ref_level_in(8'h20), .tx_div_out, .pll_sel_out,
        .cdr_rate_out, .pcs_en_out, .width_out, .tx_rate_out, .cdr_refclk_out,
        .pll_refclk_out, .pll_setting_out, .fields_written_out,
        .phase_interpolator_phase_out, .eye_sampler_ch_out(eye_ch), .eye_width_out,
        .adaptive_equalizer_ch_out(aeq_ch), .adaptive_equalizer_eq_out(aeq_eq));
    trm_req_model req (.clk_in, .wait_in(avmm_waitrequest_out),
        .rvalid_in(avmm_readdatavalid_out), .rdata_in(avmm_readdata_out),
        .addr_out(avmm_address_in), .wr_out(avmm_write_in), .rd_out(avmm_read_in),
        .data_out(avmm_writedata_in));
    ////////////////////////////////////////////////////////////////////////////
    // counts busy cycles, bounded so a stuck flag cannot hang the run
    task automatic idle(output int c);
        c = 0;
        while (busy_out !== 1'b0 && c < 2000)
        begin
            @(posedge clk_in);
            #1;
            c++;
        end
        `CHK("idle_end", 1'b0, busy_out)
    endtask : idle
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    // watchdog: the whole sequence needs well under 3000 cycles
    initial
    begin
        #100000;
        error_cnt++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        `CHK("pcs_rst", 16'hffff, pcs_en_out)
        // random dividers on random channels, others must hold
        repeat (6)
        begin
            ix = $unsigned($random(seed)) % 4;
            v = $unsigned($random(seed)) % 4;
            div[ix] = v;
            req.wr(`TRM_A_DIV, 32'(ix) | (32'(v) << 4));
            idle(n);
            `CHK("div_busy", 4, n)
            `CHK("tx_div", {2'(div[3]), 2'(div[2]), 2'(div[1]), 2'(div[0])}, tx_div_out)
        end
        $display("test dividers done");
        // refclk: non-dedicated source refused, dedicated accepted
        req.wr(`TRM_A_REFCLK, 32'h1025);
        `CHK("ref_err", 1'b1, error_out)
        `CHK("ref_keep", 8'h00, cdr_refclk_out)
        req.rd(`TRM_A_STATUS, q);
        `CHK("stat_err", 1'b1, q[0])
        req.wr(`TRM_A_STATUS, 32'h1);
        req.wr(`TRM_A_REFCLK, 32'h0025);
        idle(n);
        `CHK("cdr_ref", 8'h08, cdr_refclk_out)
        // tx-only to rx-only swap refused
        req.wr(`TRM_A_CHAN, 32'h8000);
        `CHK("swap_err", 1'b1, error_out)
        req.wr(`TRM_A_STATUS, 32'h1);
        // full, empty partial and one-field partial channel writes
        req.wr(`TRM_A_CHAN, 32'h2572);
        idle(n);
        `CHK("full_n", 16, n)
        `CHK("full_f", 4'hf, fields_written_out)
        `CHK("pcs", 16'hf5ff, pcs_en_out)
        `CHK("cdr", 8'h30, cdr_rate_out)
        `CHK("psel", 4'h4, pll_sel_out)
        req.wr(`TRM_A_CHAN, 32'h25f2);
        idle(n);
        `CHK("part0", 1, n)
        req.wr(`TRM_A_CHAN, 32'h15f2);
        idle(n);
        `CHK("part_f", 4'h8, fields_written_out)
        `CHK("width", 8'h10, width_out)
        // pll change reaches every user, refused when bonded
        req.wr(`TRM_A_PLL, 32'h31);
        idle(n);
        `CHK("tx_rate", 8'h30, tx_rate_out)
        ch_bond_in = 8'h10;
        req.wr(`TRM_A_PLL, 32'h11);
        `CHK("bond_err", 3'h7, {error_out, pll_setting_out[3:2]})
        // direct-mode and core mismatches refused, settings kept
        req.wr(`TRM_A_STATUS, 32'h1);
        `CHK("err_clr", 1'b0, error_out)
        req.wr(`TRM_A_CHAN, 32'h40001);
        `CHK("direct_err", 1'b1, error_out)
        req.wr(`TRM_A_STATUS, 32'h1);
        ch_core_in = 4'h2;
        req.wr(`TRM_A_CHAN, 32'h1);
        `CHK("core_err", 1'b1, error_out)
        `CHK("core_keep", 16'hf5ff, pcs_en_out)
        $display("test reconfig done");
        // open eye of 22 clean steps, then a closed eye
        req.wr(`TRM_A_EYE, 32'h1);
        // equalizer enable issued mid-scan stalls until the scan ends
        req.wr(`TRM_A_AEQ, 32'h100002);
        `CHK("eye_open", 6'h16, eye_width_out)
        `CHK("eye_ch", 2'h1, eye_ch)
        repeat (70) @(posedge clk_in);
        #1;
        `CHK("aeq", 6'h21, {aeq_ch, aeq_eq})
        closed = 1'b1;
        req.wr(`TRM_A_EYE, 32'h1);
        idle(n);
        `CHK("eye_shut", 6'h00, eye_width_out)
        $display("test eye done");
        conclude();
    end
endmodule : trm_top_tb
`default_nettype wire
